// [src/iors_pkg.sv]
// package: map, field masks and state types of the io register space
package iors_pkg;

  localparam int ADDR_W = 6;
  localparam int DATA_W = 8;
  localparam int BIT_W  = 3;
  localparam int NFLAGS = 8;
  localparam int LOW_N  = 32;
  localparam int HIGH_N = 32;
  localparam int LOW_AW = 5;

  localparam logic [ADDR_W-1:0] BIT_RANGE_TOP = 6'h1F;

  // ------------------------------------------------------------------
  // register addresses
  // ------------------------------------------------------------------
  localparam logic [5:0] A_CONV_CTRL_B   = 6'h03;
  localparam logic [5:0] A_CONV_RES_LO   = 6'h04;
  localparam logic [5:0] A_CONV_RES_HI   = 6'h05;
  localparam logic [5:0] A_CONV_CTRL_A   = 6'h06;
  localparam logic [5:0] A_CONV_IN_SEL   = 6'h07;
  localparam logic [5:0] A_CMP_CTRL_STAT = 6'h08;
  localparam logic [5:0] A_DIG_IN_DIS    = 6'h14;
  localparam logic [5:0] A_PIN_CHG_MASK  = 6'h15;
  localparam logic [5:0] A_PORT_IN_PINS  = 6'h16;
  localparam logic [5:0] A_PORT_DIR      = 6'h17;
  localparam logic [5:0] A_PORT_OUT      = 6'h18;
  localparam logic [5:0] A_EE_CTRL       = 6'h1C;
  localparam logic [5:0] A_EE_DATA       = 6'h1D;
  localparam logic [5:0] A_EE_ADDR       = 6'h1E;
  localparam logic [5:0] A_WDOG_CTRL     = 6'h21;
  localparam logic [5:0] A_PWR_REDUCE    = 6'h25;
  localparam logic [5:0] A_CLK_PRESCALE  = 6'h26;
  localparam logic [5:0] A_GEN_TMR_CTRL  = 6'h28;
  localparam logic [5:0] A_TMR_CMP_B     = 6'h29;
  localparam logic [5:0] A_DBG_DATA      = 6'h2E;
  localparam logic [5:0] A_TMR_CTRL_A    = 6'h2F;
  localparam logic [5:0] A_BROWNOUT_CTRL = 6'h30;
  localparam logic [5:0] A_OSC_TRIM      = 6'h31;
  localparam logic [5:0] A_TMR_COUNT     = 6'h32;
  localparam logic [5:0] A_TMR_CTRL_B    = 6'h33;
  localparam logic [5:0] A_RESET_CAUSE   = 6'h34;
  localparam logic [5:0] A_CORE_CTRL     = 6'h35;
  localparam logic [5:0] A_TMR_CMP_A     = 6'h36;
  localparam logic [5:0] A_SELF_PROG     = 6'h37;
  localparam logic [5:0] A_TMR_FLAGS     = 6'h38;
  localparam logic [5:0] A_TMR_IRQ_MASK  = 6'h39;
  localparam logic [5:0] A_EXT_IRQ_FLAGS = 6'h3A;
  localparam logic [5:0] A_EXT_IRQ_MASK  = 6'h3B;
  localparam logic [5:0] A_STACK_PTR_LO  = 6'h3D;
  localparam logic [5:0] A_CORE_STATUS   = 6'h3F;

  // ------------------------------------------------------------------
  // hardware flags: index order of the flag bank
  // ------------------------------------------------------------------
  // 0 conv done, 1 comparator, 2 watchdog, 3 overflow, 4 compare a,
  // 5 compare b, 6 external line, 7 pin change
  localparam logic [5:0] FLAG_ADDR [NFLAGS] = '{
    A_CONV_CTRL_A, A_CMP_CTRL_STAT, A_WDOG_CTRL, A_TMR_FLAGS,
    A_TMR_FLAGS, A_TMR_FLAGS, A_EXT_IRQ_FLAGS, A_EXT_IRQ_FLAGS};
  localparam logic [2:0] FLAG_BIT [NFLAGS] = '{
    3'h4, 3'h4, 3'h7, 3'h1, 3'h2, 3'h3, 3'h6, 3'h5};

  localparam logic [2:0] CMP_OUT_BIT = 3'h5;
  localparam logic [7:0] ZERO_BYTE   = 8'h00;

  // implemented bits of each address; reserved reads zero
  function automatic logic [7:0] rdMask(input logic [5:0] a);
    logic [7:0] m;
    m = ZERO_BYTE;
    unique case (a)
      A_CONV_CTRL_B:   m = 8'h47;
      A_CONV_IN_SEL:   m = 8'h63;
      A_CMP_CTRL_STAT: m = 8'hFB;
      A_DIG_IN_DIS, A_PIN_CHG_MASK, A_PORT_IN_PINS, A_PORT_DIR,
      A_PORT_OUT, A_EE_CTRL, A_EE_ADDR: m = 8'h3F;
      A_PWR_REDUCE, A_BROWNOUT_CTRL: m = 8'h03;
      A_CLK_PRESCALE:  m = 8'h8F;
      A_GEN_TMR_CTRL:  m = 8'h81;
      A_TMR_CTRL_A:    m = 8'hF3;
      A_TMR_CTRL_B:    m = 8'hCF;
      A_RESET_CAUSE:   m = 8'h0F;
      A_CORE_CTRL:     m = 8'h7B;
      A_SELF_PROG:     m = 8'h1F;
      A_TMR_FLAGS, A_TMR_IRQ_MASK: m = 8'h0E;
      A_EXT_IRQ_FLAGS, A_EXT_IRQ_MASK: m = 8'h60;
      A_CONV_RES_LO, A_CONV_RES_HI, A_CONV_CTRL_A, A_EE_DATA,
      A_WDOG_CTRL, A_TMR_CMP_B, A_DBG_DATA, A_OSC_TRIM, A_TMR_COUNT,
      A_TMR_CMP_A, A_STACK_PTR_LO, A_CORE_STATUS: m = 8'hFF;
      default:         m = ZERO_BYTE;
    endcase
    return m;
  endfunction : rdMask

  // bits that software may store: flags and live inputs excluded
  function automatic logic [7:0] wrMask(input logic [5:0] a);
    logic [7:0] ro;
    ro = ZERO_BYTE;
    unique case (a)
      A_CONV_RES_LO, A_CONV_RES_HI, A_PORT_IN_PINS,
      A_TMR_FLAGS, A_EXT_IRQ_FLAGS: ro = 8'hFF;
      A_CONV_CTRL_A:   ro = 8'h10;
      A_CMP_CTRL_STAT: ro = 8'h30;
      A_WDOG_CTRL:     ro = 8'h80;
      default:         ro = ZERO_BYTE;
    endcase
    return rdMask(a) & ~ro;
  endfunction : wrMask

  typedef struct packed {
    logic [LOW_N-1:0][DATA_W-1:0] low;
    logic                         rdPend;
    logic [ADDR_W-1:0]            rdAddr;
    logic [DATA_W-1:0]            rdData;
    logic                         rdValid;
    logic                         skip;
    logic                         testDone;
  } iors_top_state_t;

endpackage : iors_pkg

// [src/iors_if.sv]
// interfaces: flag bank and high-range store links
`timescale 1ns/1ps
`default_nettype none

interface iors_flag_if #(parameter int N = 8);
  logic [N-1:0] setEv;
  logic [N-1:0] clrReq;
  logic [N-1:0] state;
  modport bank (input setEv, input clrReq, output state);
  modport user (output setEv, output clrReq, input state);
endinterface : iors_flag_if

interface iors_mem_if #(parameter int AW = 5, parameter int DW = 8);
  logic          we;
  logic [AW-1:0] wAddr;
  logic [DW-1:0] wData;
  logic          re;
  logic [AW-1:0] rAddr;
  logic [DW-1:0] rData;
  modport store (input we, input wAddr, input wData, input re,
                 input rAddr, output rData);
  modport user (output we, output wAddr, output wData, output re,
                output rAddr, input rData);
endinterface : iors_mem_if

`default_nettype wire

// [src/iors_flag_bank.sv]
// module: sticky hardware flags with write-one clear
`timescale 1ns/1ps
`default_nettype none

module iors_flag_bank #(
  parameter int N = 8
) (
  input wire logic   clk,
  input wire logic   rst,
  iors_flag_if.bank  fl
);

  typedef struct packed {
    logic [N-1:0] flag;
  } iors_flag_state_t;

  iors_flag_state_t st_q;
  iors_flag_state_t st_d;

  // ------------------------------------------------------------------
  // per-bit next value
  // ------------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    for (int i = 0; i < N; i++) begin
      // set beats clear so an event in the clear cycle survives
      st_d.flag[i] = fl.setEv[i] | (st_q.flag[i] & ~fl.clrReq[i]);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign fl.state = st_q.flag;

endmodule : iors_flag_bank

`default_nettype wire

// [src/iors_store.sv]
// module: byte store for the upper, word-only register range
`timescale 1ns/1ps
`default_nettype none

module iors_store #(
  parameter int DEPTH = 32,
  parameter int AW    = 5,
  parameter int DW    = 8
) (
  input wire logic   clk,
  input wire logic   rst,
  iors_mem_if.store  m
);

  typedef struct packed {
    logic [DEPTH-1:0][DW-1:0] mem;
    logic [DW-1:0]            rData;
  } iors_store_state_t;

  iors_store_state_t st_q;
  iors_store_state_t st_d;

  // ------------------------------------------------------------------
  // write and registered read
  // ------------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    if (m.we) begin
      st_d.mem[m.wAddr] = m.wData;
    end
    // old data on a same-address read; the core never needs both
    if (m.re) begin
      st_d.rData = st_q.mem[m.rAddr];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign m.rData = st_q.rData;

endmodule : iors_store

`default_nettype wire

// [src/iors_space.sv]
// module: the io register space as seen by the processor core
`timescale 1ns/1ps
`default_nettype none

module iors_space #(
  parameter int NFLAGS = iors_pkg::NFLAGS
) (
  input  wire logic                        clk,
  input  wire logic                        rst,
  input  wire logic [iors_pkg::ADDR_W-1:0] ioAddr,
  input  wire logic [iors_pkg::DATA_W-1:0] ioWrData,
  input  wire logic                        ioWrEn,
  input  wire logic                        ioRdEn,
  input  wire logic [iors_pkg::BIT_W-1:0]  bitSel,
  input  wire logic                        ioBitSetInstr,
  input  wire logic                        ioBitClearInstr,
  input  wire logic                        skipIfIoBitOneInstr,
  input  wire logic                        skipIfIoBitZeroInstr,
  input  wire logic [NFLAGS-1:0]           flagSetEv,
  input  wire logic [iors_pkg::DATA_W-1:0] convResultLow,
  input  wire logic [iors_pkg::DATA_W-1:0] convResultHigh,
  input  wire logic [iors_pkg::DATA_W-1:0] pinLevel,
  input  wire logic                        comparatorOut,
  output logic [iors_pkg::DATA_W-1:0]      ioRdData,
  output logic                             ioRdValid,
  output logic                             skipNext,
  output logic                             bitTestDone,
  output logic [iors_pkg::DATA_W-1:0]      portDirection,
  output logic [iors_pkg::DATA_W-1:0]      portOutputLatch,
  output logic [NFLAGS-1:0]                flagState
);

  // ------------------------------------------------------------------
  // links to flag bank and upper store
  // ------------------------------------------------------------------
  iors_flag_if #(.N(NFLAGS)) flagLink ();
  iors_mem_if #(
    .AW (iors_pkg::LOW_AW),
    .DW (iors_pkg::DATA_W)
  ) memLink ();

  iors_flag_bank #(
    .N (NFLAGS)
  ) uFlags (
    .clk (clk),
    .rst (rst),
    .fl  (flagLink.bank)
  );

  iors_store #(
    .DEPTH (iors_pkg::HIGH_N),
    .AW    (iors_pkg::LOW_AW),
    .DW    (iors_pkg::DATA_W)
  ) uStore (
    .clk (clk),
    .rst (rst),
    .m   (memLink.store)
  );

  iors_pkg::iors_top_state_t st_q;
  iors_pkg::iors_top_state_t st_d;

  logic [NFLAGS-1:0] clrVec;
  logic              inLowTake;
  logic              inLowRead;
  logic [7:0]        wm;
  logic [7:0]        testView;
  logic [7:0]        rdView;

  // ------------------------------------------------------------------
  // composite view of one address: stored bits, flags, live inputs
  // ------------------------------------------------------------------
  function automatic logic [7:0] viewOf(
    input logic [5:0]        a,
    input logic [7:0]        stored,
    input logic [NFLAGS-1:0] flags,
    input logic [7:0]        resLo,
    input logic [7:0]        resHi,
    input logic [7:0]        pins,
    input logic              cmpOut
  );
    logic [7:0] v;
    v = stored;
    unique case (a)
      iors_pkg::A_CONV_RES_LO:   v = resLo;
      iors_pkg::A_CONV_RES_HI:   v = resHi;
      iors_pkg::A_PORT_IN_PINS:  v = pins;
      iors_pkg::A_CMP_CTRL_STAT: v[iors_pkg::CMP_OUT_BIT] = cmpOut;
      default:                   v = stored;
    endcase
    for (int i = 0; i < NFLAGS; i++) begin
      if (a == iors_pkg::FLAG_ADDR[i]) begin
        v[iors_pkg::FLAG_BIT[i]] = flags[i];
      end
    end
    // reserved positions and addresses always read zero
    return v & iors_pkg::rdMask(a);
  endfunction : viewOf

  // ------------------------------------------------------------------
  // flag clear requests
  // ------------------------------------------------------------------
  always_comb begin
    clrVec = '0;
    for (int i = 0; i < NFLAGS; i++) begin
      if (ioWrEn && ioAddr == iors_pkg::FLAG_ADDR[i]) begin
        // a written one clears, a written zero leaves the flag
        clrVec[i] = ioWrData[iors_pkg::FLAG_BIT[i]];
      end else if (!ioWrEn && ioBitSetInstr && inLowTake
                   && ioAddr == iors_pkg::FLAG_ADDR[i]) begin
        // only the addressed flag sees the one, siblings are kept
        clrVec[i] = (bitSel == iors_pkg::FLAG_BIT[i]);
      end
    end
  end

  assign flagLink.setEv  = flagSetEv;
  assign flagLink.clrReq = clrVec;

  // ------------------------------------------------------------------
  // request decode
  // ------------------------------------------------------------------
  assign inLowTake = (ioAddr <= iors_pkg::BIT_RANGE_TOP);
  assign inLowRead = (st_q.rdAddr <= iors_pkg::BIT_RANGE_TOP);
  assign wm        = iors_pkg::wrMask(ioAddr);

  assign testView = viewOf(ioAddr, st_q.low[ioAddr[iors_pkg::LOW_AW-1:0]],
                           flagLink.state, convResultLow, convResultHigh,
                           pinLevel, comparatorOut);

  assign rdView = viewOf(st_q.rdAddr,
                         inLowRead ?
                           st_q.low[st_q.rdAddr[iors_pkg::LOW_AW-1:0]] :
                           memLink.rData,
                         flagLink.state, convResultLow, convResultHigh,
                         pinLevel, comparatorOut);

  // upper range: word writes only, reserved bits never stored
  assign memLink.we    = ioWrEn && !inLowTake;
  assign memLink.wAddr = ioAddr[iors_pkg::LOW_AW-1:0];
  assign memLink.wData = ioWrData & wm;
  assign memLink.re    = ioRdEn && !inLowTake;
  assign memLink.rAddr = ioAddr[iors_pkg::LOW_AW-1:0];

  // ------------------------------------------------------------------
  // next state
  // ------------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    // word write wins over a bit operation in the same cycle
    if (ioWrEn && inLowTake) begin
      st_d.low[ioAddr[iors_pkg::LOW_AW-1:0]] =
        (st_q.low[ioAddr[iors_pkg::LOW_AW-1:0]] & ~wm) | (ioWrData & wm);
    end else if (ioBitSetInstr && inLowTake) begin
      // single-bit update, no read-modify-write of the byte
      if (wm[bitSel]) begin
        st_d.low[ioAddr[iors_pkg::LOW_AW-1:0]][bitSel] = 1'b1;
      end
    end else if (ioBitClearInstr && inLowTake) begin
      if (wm[bitSel]) begin
        st_d.low[ioAddr[iors_pkg::LOW_AW-1:0]][bitSel] = 1'b0;
      end
    end

    // bit test answers next cycle; upper range is refused
    st_d.testDone = (skipIfIoBitOneInstr || skipIfIoBitZeroInstr)
                    && inLowTake;
    st_d.skip = inLowTake &&
                ((skipIfIoBitOneInstr && testView[bitSel]) ||
                 (skipIfIoBitZeroInstr && !testView[bitSel]));

    // reads pass a capture stage so the store data is registered
    st_d.rdPend  = ioRdEn;
    st_d.rdAddr  = ioRdEn ? ioAddr : st_q.rdAddr;
    st_d.rdValid = st_q.rdPend;
    st_d.rdData  = st_q.rdPend ? rdView : st_q.rdData;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // ------------------------------------------------------------------
  // outputs, all from flip-flops
  // ------------------------------------------------------------------
  assign ioRdData        = st_q.rdData;
  assign ioRdValid       = st_q.rdValid;
  assign skipNext        = st_q.skip;
  assign bitTestDone     = st_q.testDone;
  assign portDirection   =
    st_q.low[iors_pkg::A_PORT_DIR[iors_pkg::LOW_AW-1:0]];
  assign portOutputLatch =
    st_q.low[iors_pkg::A_PORT_OUT[iors_pkg::LOW_AW-1:0]];
  assign flagState       = flagLink.state;

endmodule : iors_space

`default_nettype wire

// [dv/iors_space_sva.sv]
// checker: port-level properties of the io register space
`timescale 1ns/1ps
`default_nettype none
module iors_space_chk #(
  parameter int NFLAGS = 8
) (
  input wire logic              clk,
  input wire logic              rst,
  input wire logic [5:0]        ioAddr,
  input wire logic [7:0]        ioWrData,
  input wire logic              ioWrEn,
  input wire logic              ioRdEn,
  input wire logic [2:0]        bitSel,
  input wire logic              ioBitSetInstr,
  input wire logic              ioBitClearInstr,
  input wire logic              skipIfIoBitOneInstr,
  input wire logic              skipIfIoBitZeroInstr,
  input wire logic [NFLAGS-1:0] flagSetEv,
  input wire logic              ioRdValid,
  input wire logic              skipNext,
  input wire logic              bitTestDone,
  input wire logic [7:0]        portOutputLatch,
  input wire logic [NFLAGS-1:0] flagState
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic tst;
  logic lowA;
  logic latchBit;
  logic setP;
  assign tst = skipIfIoBitOneInstr | skipIfIoBitZeroInstr;
  assign lowA = ioAddr <= 6'h1F;
  assign latchBit = portOutputLatch[bitSel];
  assign setP = ioBitSetInstr && !ioWrEn && ioAddr == 6'h18;
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  a_read_two: assert property (ioRdEn |-> ##2 ioRdValid)
    else $error("read answer missing");
  a_valid_src: assert property (ioRdValid |-> $past(ioRdEn, 2))
    else $error("read answer without request");
  a_test_low: assert property (tst && lowA |=> bitTestDone)
    else $error("bit test unanswered");
  a_test_high: assert property (tst && !lowA |=>
    !bitTestDone && !skipNext) else $error("high bit test answered");
  a_skip_one: assert property (skipIfIoBitOneInstr &&
    !skipIfIoBitZeroInstr && ioAddr == 6'h18 |=> skipNext == $past(latchBit))
    else $error("skip on one wrong");
  a_skip_zero: assert property (skipIfIoBitZeroInstr &&
    !skipIfIoBitOneInstr && ioAddr == 6'h18 |=> skipNext != $past(latchBit))
    else $error("skip on zero wrong");
  a_set_only: assert property (setP && bitSel < 3'h6 |=>
    portOutputLatch == ($past(portOutputLatch) | (8'h01 << $past(bitSel))))
    else $error("bit set touched other bits");
  a_clr_only: assert property (ioBitClearInstr && !ioBitSetInstr &&
    !ioWrEn && ioAddr == 6'h18 |=>
    portOutputLatch == ($past(portOutputLatch) & ~(8'h01 << $past(bitSel))))
    else $error("bit clear wrong");
  a_flag_w1c: assert property (ioWrEn && ioAddr == 6'h38 &&
    ioWrData[2] && !flagSetEv[4] |=> !flagState[4])
    else $error("flag not cleared by one");
  a_flag_keep: assert property (ioWrEn && ioAddr == 6'h38 &&
    !ioWrData[1] && flagState[3] |=> flagState[3])
    else $error("flag lost on zero write");
  a_read_quiet: assert property (ioRdEn && !ioWrEn &&
    !ioBitSetInstr && flagSetEv == '0 |=> $stable(flagState))
    else $error("read changed flags");
endmodule : iors_space_chk
bind iors_space iors_space_chk #(.NFLAGS(NFLAGS)) chk (
  .clk(clk), .rst(rst), .ioAddr(ioAddr), .ioWrData(ioWrData),
  .ioWrEn(ioWrEn), .ioRdEn(ioRdEn), .bitSel(bitSel),
  .ioBitSetInstr(ioBitSetInstr), .ioBitClearInstr(ioBitClearInstr),
  .skipIfIoBitOneInstr(skipIfIoBitOneInstr),
  .skipIfIoBitZeroInstr(skipIfIoBitZeroInstr), .flagSetEv(flagSetEv),
  .ioRdValid(ioRdValid), .skipNext(skipNext), .bitTestDone(bitTestDone),
  .portOutputLatch(portOutputLatch), .flagState(flagState)
);
`default_nettype wire

// [dv/iors_core_model.sv]
// partner: processor core issuing io instructions
`timescale 1ns/1ps
`default_nettype none
module iors_core_model (
  input  wire logic  clk,
  output logic [5:0] ioAddr,
  output logic [7:0] ioWrData,
  output logic [2:0] bitSel,
  output logic [5:0] opVec
);
  initial begin
    ioAddr = 6'h00;
    ioWrData = 8'h00;
    bitSel = 3'h0;
    opVec = 6'h00;
  end
  // op bits: write, read, set, clear, skip-one, skip-zero
  // callers keep reserved bits zero and skip reserved stores
  task automatic issue(input logic [5:0] a, input logic [7:0] d,
                       input logic [2:0] b, input logic [5:0] op);
    @(posedge clk);
    ioAddr <= a;
    ioWrData <= d;
    bitSel <= b;
    opVec <= op;
    @(posedge clk);
    opVec <= 6'h00;
    // address and data lines flip so a stale value cannot pass for a live one
    ioAddr <= ~a;
    ioWrData <= ~d;
  endtask : issue
endmodule : iors_core_model
`default_nettype wire

// [dv/testbench.sv]
// testbench: self-checking run of the io register space
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin failCount++; \
  $display("MISMATCH %s exp %h got %h", n, e, g); end end
module testbench;
  logic       clk;
  logic       rst;
  logic [5:0] ioAddr;
  logic [7:0] ioWrData;
  logic [2:0] bitSel;
  logic [5:0] op;
  logic [7:0] flagSetEv;
  logic [7:0] resLo;
  logic [7:0] resHi;
  logic [7:0] pins;
  logic       cmpOut;
  logic [7:0] ioRdData;
  logic       ioRdValid;
  logic       skipNext;
  logic       bitTestDone;
  logic [7:0] portDirection;
  logic [7:0] portOutputLatch;
  logic [7:0] flagState;
  logic [7:0] rdQ [$];
  logic       skQ [$];
  logic [7:0] d;
  logic [7:0] e;
  logic [7:0] rdExp;
  logic       skExp;
  logic [5:0] rsvAddr [5] = '{6'h00, 6'h02, 6'h1F, 6'h2A, 6'h3E};
  int         failCount = 0;
  int         checked = 0;
  iors_core_model core (.clk(clk), .ioAddr(ioAddr), .ioWrData(ioWrData),
    .bitSel(bitSel), .opVec(op));
  iors_space uut (.clk(clk), .rst(rst), .ioAddr(ioAddr),
    .ioWrData(ioWrData), .ioWrEn(op[5]), .ioRdEn(op[4]), .bitSel(bitSel),
    .ioBitSetInstr(op[3]), .ioBitClearInstr(op[2]),
    .skipIfIoBitOneInstr(op[1]), .skipIfIoBitZeroInstr(op[0]),
    .flagSetEv(flagSetEv), .convResultLow(resLo), .convResultHigh(resHi),
    .pinLevel(pins), .comparatorOut(cmpOut), .ioRdData(ioRdData),
    .ioRdValid(ioRdValid), .skipNext(skipNext), .bitTestDone(bitTestDone),
    .portDirection(portDirection), .portOutputLatch(portOutputLatch),
    .flagState(flagState));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic rdx(input logic [5:0] a, input logic [7:0] x);
    rdQ.push_back(x);
    core.issue(a, 8'h00, 3'h0, 6'h10);
  endtask : rdx
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", checked, failCount);
    if (failCount == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : give_verdict
  // ------------------------------------------------------------------
  // monitor: answers are matched against the oldest note
  // ------------------------------------------------------------------
  always @(negedge clk) begin
    if (ioRdValid === 1'b1) begin
      if (rdQ.size() == 0) `CHK("unasked read", 1'b0, 1'b1)
      else begin
        // pop once: the macro names its expected value twice
        rdExp = rdQ.pop_front();
        `CHK("read data", rdExp, ioRdData)
      end
    end
    if (bitTestDone === 1'b1) begin
      if (skQ.size() == 0) `CHK("unasked test", 1'b0, 1'b1)
      else begin
        skExp = skQ.pop_front();
        `CHK("skip", skExp, skipNext)
      end
    end
  end
  initial begin
    repeat (5000) @(posedge clk);
    failCount++;
    give_verdict();
  end
  initial begin
    rst = 1'b1;
    flagSetEv = 8'h00;
    cmpOut = 1'b1;
    void'($urandom(97));
    resLo = 8'($urandom);
    resHi = 8'($urandom);
    pins = 8'($urandom);
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    `CHK("direction", 8'h00, portDirection)
    `CHK("flags", 8'h00, flagState)
    for (int i = 0; i < 6; i++) begin
      d = 8'($urandom);
      core.issue(6'h17, d & 8'h3F, 3'h0, 6'h20);
      core.issue(6'h2E, d, 3'h0, 6'h20);
      rdx(6'h17, d & 8'h3F);
      rdx(6'h2E, d);
      `CHK("direction", d & 8'h3F, portDirection)
    end
    rdx(6'h04, resLo);
    rdx(6'h05, resHi);
    rdx(6'h16, pins & 8'h3F);
    foreach (rsvAddr[k]) begin
      rdx(rsvAddr[k], 8'h00);
    end
    $display("test words done");
    core.issue(6'h18, 8'h00, 3'h0, 6'h20);
    e = 8'h00;
    for (int b = 0; b < 6; b++) begin
      core.issue(6'h18, 8'h00, 3'(b), (b % 2) ? 6'h08 : 6'h04);
      e[b] = b % 2;
      @(negedge clk);
      `CHK("latch", e, portOutputLatch)
      skQ.push_back(e[b]);
      core.issue(6'h18, 8'h00, 3'(b), 6'h02);
      skQ.push_back(!e[b]);
      core.issue(6'h18, 8'h00, 3'(b), 6'h01);
    end
    core.issue(6'h2F, 8'h00, 3'h0, 6'h20);
    core.issue(6'h2F, 8'h00, 3'h0, 6'h08);
    core.issue(6'h2F, 8'h00, 3'h0, 6'h02);
    rdx(6'h2F, 8'h00);
    $display("test bits done");
    core.issue(6'h06, 8'h27, 3'h0, 6'h20);
    @(posedge clk);
    flagSetEv <= 8'hFF;
    @(posedge clk);
    flagSetEv <= 8'h00;
    core.issue(6'h38, 8'h00, 3'h0, 6'h20);
    @(negedge clk);
    `CHK("flags kept", 8'hFF, flagState)
    core.issue(6'h38, 8'h04, 3'h0, 6'h20);
    @(negedge clk);
    `CHK("flag clear", 8'hEF, flagState)
    core.issue(6'h06, 8'h00, 3'h4, 6'h08);
    core.issue(6'h08, 8'h00, 3'h4, 6'h04);
    @(negedge clk);
    `CHK("one flag", 8'hEE, flagState)
    rdx(6'h06, 8'h27);
    rdx(6'h08, 8'h30);
    rdx(6'h38, 8'h0A);
    rdx(6'h3A, 8'h60);
    repeat (6) @(posedge clk);
    `CHK("pending", 0, rdQ.size() + skQ.size())
    $display("test flags done");
    give_verdict();
  end
endmodule : testbench
`default_nettype wire
